// File: tcu_consts.vh
// constants and register map of the 8-bit single compare timer unit
`ifndef TCU_CONSTS_VH
`define TCU_CONSTS_VH

// ----------------------------------------
// register offsets (4-bit address)
// ----------------------------------------
`define TCU_ADDR_CTRL_A 4'h0
`define TCU_ADDR_CTRL_B 4'h1
`define TCU_ADDR_COUNT 4'h2
`define TCU_ADDR_COMPARE 4'h3
`define TCU_ADDR_IRQ_MASK 4'h4
`define TCU_ADDR_IRQ_FLAG 4'h5
`define TCU_ADDR_ASYNC 4'h6

// ----------------------------------------
// field positions
// ----------------------------------------
// control_reg_a: [7] force strobe, [5:4] output mode, [1:0] waveform mode
`define TCU_CTRLA_FORCE 7
`define TCU_CTRLA_COM_HI 5
`define TCU_CTRLA_COM_LO 4
`define TCU_CTRLA_WGM_HI 1
`define TCU_CTRLA_WGM_LO 0
// control_reg_b: [2:0] clock select
`define TCU_CTRLB_CS_HI 2
`define TCU_CTRLB_CS_LO 0
// mask and flag: [1] compare, [0] overflow
`define TCU_IRQ_CMP 1
`define TCU_IRQ_OVF 0
// async status: [0] async clock select
`define TCU_ASYNC_SEL 0

// ----------------------------------------
// values and reset values
// ----------------------------------------
`define TCU_BOTTOM 8'h00
`define TCU_MAX 8'hff
`define TCU_RST_BYTE 8'h00
`define TCU_WGM_NORMAL 2'h0
`define TCU_WGM_PCPWM 2'h1
`define TCU_WGM_CTC 2'h2
`define TCU_WGM_FASTPWM 2'h3
`define TCU_CS_STOP 3'h0

`endif

// File: tcu_edge_sync.v
// three-stage synchroniser with agreement detect for an external clock pin
`timescale 1ns/1ns
module tcu_edge_sync
(
  // clock and reset
  input wire sys_clk,
  input wire nrst,
  // pin and result
  input wire pin,
  output reg rise
);

reg sync_a;
reg sync_b;
reg sync_c;
reg level;

// stage a is read only by stage b; a change counts once b and c agree
always @(posedge sys_clk)
begin
  if (!nrst)
  begin
    sync_a <= 1'b0;
    sync_b <= 1'b0;
    sync_c <= 1'b0;
    level <= 1'b0;
    rise <= 1'b0;
  end
  else
  begin
    sync_a <= pin;
    sync_b <= sync_a;
    sync_c <= sync_b;
    if (sync_b == sync_c)
      level <= sync_c;
    rise <= (sync_b == sync_c) && sync_c && !level;
  end
end

endmodule // tcu_edge_sync

// File: tcu_timer.v
// 8-bit up/down timer with one compare channel, register port and waveform output
`timescale 1ns/1ns
`include "tcu_consts.vh"
module tcu_timer
(
  // clock and reset
  input wire sys_clk,
  input wire nrst,
  // register port
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [7:0] rdata,
  // interrupt acknowledges from the cpu core
  input wire ovf_irq_ack,
  input wire cmp_irq_ack,
  // crystal oscillator clock on crystal_pin_one
  input wire crystal_pin_one,
  // outputs
  output reg compare_output,
  output reg ovf_irq,
  output reg cmp_irq
);

// ----------------------------------------
// registers
// ----------------------------------------
// software-visible state
reg [7:0] count_value;
reg [7:0] compare_value; // active compare register
reg [7:0] compare_buf; // buffer written in pwm modes
reg [1:0] waveform_mode_bits;
reg [1:0] compare_output_mode;
reg [2:0] clock_select_bits;
reg async_clock_select;
reg compare_irq_enable;
reg overflow_irq_enable;
reg compare_flag;
reg overflow_flag;
// counter internals
reg count_down; // direction for phase-correct pwm
reg match_block; // set by a count write, eaten by the next timer tick
reg match_q; // match seen on the last tick, flags on the next
reg [9:0] prescale;
reg [9:0] next_prescale;
reg [7:0] next_count;
reg next_down;
reg tick; // one timer clock
reg pwm_mode;
reg cmp_match;
reg force_now;
reg wr_count;
reg wr_compare;
reg wr_flag;
// decoded strobes and tick events
reg wr_ctrl_a;
reg wr_ctrl_b;
reg wr_mask;
reg wr_async;
reg match_live; // comparator match not blocked by a count write
reg ovf_event; // tick on which the overflow flag is set
reg buf_load; // tick on which the pwm buffer reaches the active register
wire osc_rise;

// crystal clock sampled through three flip-flops
// the crystal is far slower than sys_clk, so each of its rising edges is one pulse
tcu_edge_sync u_osc_sync
(
  .sys_clk(sys_clk),
  .nrst(nrst),
  .pin(crystal_pin_one),
  .rise(osc_rise)
);

// ----------------------------------------
// helpers
// ----------------------------------------
// prescaler tap; the same divider serves both clock sources
function tap_hit;
  input [2:0] sel;
  input [9:0] cnt;
  begin
    case (sel)
      3'h1: tap_hit = 1'b1;
      3'h2: tap_hit = (cnt[2:0] == 3'h0);
      3'h3: tap_hit = (cnt[4:0] == 5'h00);
      3'h4: tap_hit = (cnt[5:0] == 6'h00);
      3'h5: tap_hit = (cnt[6:0] == 7'h00);
      3'h6: tap_hit = (cnt[7:0] == 8'h00);
      3'h7: tap_hit = (cnt[9:0] == 10'h000);
      default: tap_hit = 1'b0;
    endcase
  end
endfunction

// new compare_output for a match under the given output mode and waveform mode
function wave_on_match;
  input [1:0] com;
  input [1:0] wgm;
  input down;
  input cur;
  begin
    wave_on_match = cur;
    if (com == 2'h1 && (wgm == `TCU_WGM_NORMAL || wgm == `TCU_WGM_CTC))
      wave_on_match = ~cur;
    else if (com == 2'h2)
      wave_on_match = (wgm == `TCU_WGM_PCPWM) ? down : 1'b0;
    else if (com == 2'h3)
      wave_on_match = (wgm == `TCU_WGM_PCPWM) ? ~down : 1'b1;
  end
endfunction

// ----------------------------------------
// decode and clock select
// ----------------------------------------
// strobes decoded from the port; one-hot address compare
always @*
begin
  wr_ctrl_a = wr_en && (addr == `TCU_ADDR_CTRL_A);
  wr_ctrl_b = wr_en && (addr == `TCU_ADDR_CTRL_B);
  wr_count = wr_en && (addr == `TCU_ADDR_COUNT);
  wr_compare = wr_en && (addr == `TCU_ADDR_COMPARE);
  wr_mask = wr_en && (addr == `TCU_ADDR_IRQ_MASK);
  wr_flag = wr_en && (addr == `TCU_ADDR_IRQ_FLAG);
  wr_async = wr_en && (addr == `TCU_ADDR_ASYNC);
  pwm_mode = waveform_mode_bits[0]; // modes 1 and 3 are pwm
  force_now = wr_ctrl_a && wdata[`TCU_CTRLA_FORCE] && !pwm_mode;
end

// timer clock from io_clock or the oscillator, gated off when stopped
always @*
begin
  next_prescale = prescale;
  tick = 1'b0;
  if (clock_select_bits != `TCU_CS_STOP)
  begin
    if (!async_clock_select || osc_rise)
    begin
      next_prescale = prescale + 10'h001;
      tick = tap_hit(clock_select_bits, prescale);
    end
  end
end

// comparator runs continuously on the active register
always @*
begin
  cmp_match = (count_value == compare_value);
end

// ----------------------------------------
// counter sequence
// ----------------------------------------
// next count per waveform mode
always @*
begin
  next_count = count_value;
  next_down = count_down;
  case (waveform_mode_bits)
    `TCU_WGM_NORMAL:
      next_count = count_value + 8'h01;
    `TCU_WGM_CTC:
      next_count = match_live ? `TCU_BOTTOM : count_value + 8'h01;
    `TCU_WGM_PCPWM:
    begin
      if (!count_down && count_value == `TCU_MAX)
      begin
        next_down = 1'b1;
        next_count = count_value - 8'h01;
      end
      else if (count_down && count_value == `TCU_BOTTOM)
      begin
        next_down = 1'b0;
        next_count = count_value + 8'h01;
      end
      else if (count_down)
        next_count = count_value - 8'h01;
      else
        next_count = count_value + 8'h01;
    end
    default:
      next_count = count_value + 8'h01; // fast pwm wraps at MAX
  endcase
end

// ----------------------------------------
// tick events
// ----------------------------------------
// what a tick means is decided once, so counter, flags and waveform agree
always @*
begin
  match_live = cmp_match && !match_block;
  ovf_event = 1'b0;
  buf_load = 1'b0;
  if (tick)
  begin
    // normal, ctc and fast pwm overflow as the count wraps from MAX to zero; pwm turns at BOTTOM
    if (waveform_mode_bits != `TCU_WGM_PCPWM)
      ovf_event = (count_value == `TCU_MAX) && (next_count == `TCU_BOTTOM);
    else
      ovf_event = count_down && (count_value == `TCU_BOTTOM);
    // a compare write in the same cycle lands in the buffer and waits for the next reload
    if (pwm_mode && !wr_compare)
    begin
      if (waveform_mode_bits == `TCU_WGM_FASTPWM)
        buf_load = (next_count == `TCU_BOTTOM);
      else
        buf_load = (count_value == `TCU_MAX);
    end
  end
end

// ----------------------------------------
// state update
// ----------------------------------------
always @(posedge sys_clk)
begin
  if (!nrst)
  begin
    count_value <= `TCU_RST_BYTE;
    compare_value <= `TCU_RST_BYTE;
    compare_buf <= `TCU_RST_BYTE;
    waveform_mode_bits <= `TCU_WGM_NORMAL;
    compare_output_mode <= 2'h0;
    clock_select_bits <= `TCU_CS_STOP;
    async_clock_select <= 1'b0;
    compare_irq_enable <= 1'b0;
    overflow_irq_enable <= 1'b0;
    compare_flag <= 1'b0;
    overflow_flag <= 1'b0;
    count_down <= 1'b0;
    match_block <= 1'b0;
    match_q <= 1'b0;
    prescale <= 10'h000;
    compare_output <= 1'b0;
  end
  else
  begin
    prescale <= next_prescale;
    // control writes; output mode applies from the next cycle, so a force in the same write uses the old mode
    // the force bit is a strobe: it is never stored and reads back as zero
    if (wr_ctrl_a)
    begin
      compare_output_mode <= wdata[`TCU_CTRLA_COM_HI:`TCU_CTRLA_COM_LO];
      waveform_mode_bits <= wdata[`TCU_CTRLA_WGM_HI:`TCU_CTRLA_WGM_LO];
    end
    if (wr_ctrl_b)
      clock_select_bits <= wdata[`TCU_CTRLB_CS_HI:`TCU_CTRLB_CS_LO];
    if (wr_async)
      async_clock_select <= wdata[`TCU_ASYNC_SEL];
    if (wr_mask)
    begin
      compare_irq_enable <= wdata[`TCU_IRQ_CMP];
      overflow_irq_enable <= wdata[`TCU_IRQ_OVF];
    end
    // compare writes go to buffer in pwm modes, else straight through
    if (wr_compare)
    begin
      compare_buf <= wdata;
      if (!pwm_mode)
        compare_value <= wdata;
    end
    // a write arms the block, the next tick consumes it
    if (wr_count)
      match_block <= 1'b1;
    else if (tick)
      match_block <= 1'b0;
    // counter: a software write wins over any tick
    if (wr_count)
      count_value <= wdata;
    else if (tick)
    begin
      count_value <= next_count;
      count_down <= next_down;
    end
    // pwm buffer load: fast pwm at BOTTOM, phase-correct at TOP
    if (buf_load)
      compare_value <= compare_buf;
    // latch match on a tick, flag it on the following tick
    if (tick)
      match_q <= match_live;
    // compare flag: set beats the clear
    if (tick && match_q)
      compare_flag <= 1'b1;
    else if (cmp_irq_ack || (wr_flag && wdata[`TCU_IRQ_CMP]))
      compare_flag <= 1'b0;
    // overflow: MAX wraps to zero in normal/ctc/fast, turns at BOTTOM in pwm
    if (ovf_event)
      overflow_flag <= 1'b1;
    else if (ovf_irq_ack || (wr_flag && wdata[`TCU_IRQ_OVF]))
      overflow_flag <= 1'b0;
    // waveform generator; state is kept across mode changes
    if (force_now)
      compare_output <= wave_on_match(compare_output_mode, waveform_mode_bits,
        count_down, compare_output);
    else if (tick && match_live && compare_output_mode != 2'h0)
      compare_output <= wave_on_match(compare_output_mode, waveform_mode_bits,
        count_down, compare_output);
    else if (tick && waveform_mode_bits == `TCU_WGM_FASTPWM && next_count == `TCU_BOTTOM
        && compare_output_mode[1])
      compare_output <= ~compare_output_mode[0];
  end
end

// ----------------------------------------
// interrupt requests and read port
// ----------------------------------------
always @(posedge sys_clk)
begin
  if (!nrst)
  begin
    ovf_irq <= 1'b0;
    cmp_irq <= 1'b0;
    rdata <= `TCU_RST_BYTE;
  end
  else
  begin
    ovf_irq <= overflow_flag && overflow_irq_enable;
    cmp_irq <= compare_flag && compare_irq_enable;
    // idle cycles and unmapped addresses read as zero
    rdata <= `TCU_RST_BYTE;
    if (rd_en)
    begin
      if (addr == `TCU_ADDR_CTRL_A)
        rdata <= {2'h0, compare_output_mode, 2'h0, waveform_mode_bits};
      else if (addr == `TCU_ADDR_CTRL_B)
        rdata <= {5'h00, clock_select_bits};
      else if (addr == `TCU_ADDR_COUNT)
        rdata <= count_value;
      else if (addr == `TCU_ADDR_COMPARE)
        rdata <= pwm_mode ? compare_buf : compare_value;
      else if (addr == `TCU_ADDR_IRQ_MASK)
        rdata <= {6'h00, compare_irq_enable, overflow_irq_enable};
      else if (addr == `TCU_ADDR_IRQ_FLAG)
        rdata <= {6'h00, compare_flag, overflow_flag};
      else if (addr == `TCU_ADDR_ASYNC)
        rdata <= {7'h00, async_clock_select};
    end
  end
end

endmodule // tcu_timer

// File: tcu_timer_monitor.sv
// port-level checker for the 8-bit single compare timer
`timescale 1ns/1ns
module tcu_timer_monitor
(
  // clock and reset
  input wire sys_clk,
  input wire nrst,
  // register port
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] rdata,
  // acknowledges and pins
  input wire ovf_irq_ack,
  input wire cmp_irq_ack,
  input wire crystal_pin_one,
  // outputs
  input wire compare_output,
  input wire ovf_irq,
  input wire cmp_irq
);
  reg [2:0] cs_sh;
  reg [1:0] com_sh;
  reg [1:0] wgm_sh;
  reg [1:0] mask_sh;
  reg [7:0] cnt_sh;
  reg [7:0] cmp_sh;
  reg cnt_ok;
  reg cmp_ok;
  reg [1:0] still;

  // ----------------------------------------
  // shadow of software writes
  // ----------------------------------------
  // count shadow is trusted only while the clock has stayed stopped since the write
  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      cs_sh <= 3'h0;
      com_sh <= 2'h0;
      wgm_sh <= 2'h0;
      mask_sh <= 2'h0;
      cnt_sh <= 8'h00;
      cmp_sh <= 8'h00;
      cnt_ok <= 1'b1;
      cmp_ok <= 1'b1;
    end
    else if (wr_en)
    begin
      case (addr)
        4'h0:
        begin
          com_sh <= wdata[5:4];
          wgm_sh <= wdata[1:0];
          if (wdata[0])
            cmp_ok <= 1'b0;
        end
        4'h1:
        begin
          cs_sh <= wdata[2:0];
          cnt_ok <= 1'b0;
        end
        4'h2:
        begin
          cnt_sh <= wdata;
          cnt_ok <= (cs_sh == 3'h0);
        end
        4'h3:
        begin
          cmp_sh <= wdata;
          cmp_ok <= !wgm_sh[0];
        end
        4'h4: mask_sh <= wdata[1:0];
        default: ;
      endcase
    end
  end

  // cycles the clock select has been zero, saturating at 3
  always @(posedge sys_clk)
  begin
    if (!nrst || cs_sh != 3'h0 || (wr_en && addr == 4'h1))
      still <= 2'h0;
    else if (still != 2'h3)
      still <= still + 2'h1;
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_rdata_idle_zero: assert property (!$past(rd_en) |-> rdata == 8'h00)
    else $error("read data not zero outside read");
  a_count_read_back: assert property (rd_en && addr == 4'h2 && cnt_ok |=> rdata == cnt_sh)
    else $error("stopped count read mismatch");
  a_compare_read_back: assert property (rd_en && addr == 4'h3 && cmp_ok |=> rdata == cmp_sh)
    else $error("compare read mismatch");
  a_cmp_irq_masked: assert property (cmp_irq |-> $past(mask_sh[1]))
    else $error("compare irq while masked");
  a_ovf_irq_masked: assert property (ovf_irq |-> $past(mask_sh[0]))
    else $error("overflow irq while masked");
  a_cmp_fall_cause: assert property ($fell(cmp_irq) |-> $past(cmp_irq_ack, 2) || $past(wr_en, 2))
    else $error("compare irq dropped without cause");
  a_ovf_fall_cause: assert property ($fell(ovf_irq) |-> $past(ovf_irq_ack, 2) || $past(wr_en, 2))
    else $error("overflow irq dropped without cause");
  a_force_sets_out: assert property (wr_en && addr == 4'h0 && wdata == 8'hb0 && com_sh == 2'h3
    && wgm_sh == 2'h0 && still == 2'h3 |-> ##[1:2] compare_output)
    else $error("force did not set output");
  a_force_clears_out: assert property (wr_en && addr == 4'h0 && wdata == 8'ha0 && com_sh == 2'h2
    && wgm_sh == 2'h0 && still == 2'h3 |-> ##[1:2] !compare_output)
    else $error("force did not clear output");
  a_stopped_out_holds: assert property (still == 2'h3 && !$past(wr_en) && !$past(wr_en, 2)
    |-> $stable(compare_output))
    else $error("output moved while stopped");

  c_cmp_irq: cover property ($rose(cmp_irq));
  c_ovf_irq: cover property ($rose(ovf_irq));
  c_out_toggle_run: cover property ($changed(compare_output) && cs_sh != 3'h0);
endmodule // tcu_timer_monitor

bind tcu_timer tcu_timer_monitor u_tcu_timer_monitor (.sys_clk(sys_clk), .nrst(nrst),
  .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
  .ovf_irq_ack(ovf_irq_ack), .cmp_irq_ack(cmp_irq_ack), .crystal_pin_one(crystal_pin_one),
  .compare_output(compare_output), .ovf_irq(ovf_irq), .cmp_irq(cmp_irq));

// File: tcu_timer_test.sv
// self-checking testbench for the 8-bit single compare timer
`timescale 1ns/1ns
module tcu_timer_test;
  logic sys_clk;
  logic nrst;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic wr_en;
  logic rd_en;
  logic [7:0] rdata;
  logic ovf_irq_ack;
  logic cmp_irq_ack;
  logic crystal_pin_one = 1'b0;
  logic compare_output;
  logic ovf_irq;
  logic cmp_irq;
  logic [4:0] xdiv = 5'h00;
  logic [7:0] v;
  int bad_count;
  int samples_checked;
  int cycles = 0;

  tcu_timer u_tcu_timer (.sys_clk(sys_clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .ovf_irq_ack(ovf_irq_ack),
    .cmp_irq_ack(cmp_irq_ack), .crystal_pin_one(crystal_pin_one),
    .compare_output(compare_output), .ovf_irq(ovf_irq), .cmp_irq(cmp_irq));

  // ----------------------------------------
  // clocks and watchdog
  // ----------------------------------------
  // 100 MHz system clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // slow crystal stand-in, period 32 system cycles
  always @(posedge sys_clk)
  begin
    xdiv <= xdiv + 5'h01;
    crystal_pin_one <= xdiv[4];
  end

  // whole run needs well under a thousand cycles
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      bad_count = bad_count + 1;
      finish_test();
    end
  end

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    // let the outputs launched by this edge settle before the caller looks
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      bad_count = bad_count + 1;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task rchk(input logic [3:0] a, input logic [7:0] exp);
    rd(a, v);
    chk(v, exp);
  endtask

  task finish_test();
    $display("mismatches=%0d checks=%0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    nrst = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    ovf_irq_ack = 1'b0;
    cmp_irq_ack = 1'b0;
    bad_count = 0;
    samples_checked = 0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    // reset values, unmapped address 7 included
    for (int i = 0; i < 8; i++) rchk(i[3:0], 8'h00);
    wr(4'h2, 8'h5a);
    wr(4'h3, 8'ha5);
    rchk(4'h2, 8'h5a);
    rchk(4'h3, 8'ha5);
    // forced compare while stopped: set, clear, clear again without a flag, mode change
    wr(4'h0, 8'h30);
    wr(4'h0, 8'hb0);
    chk({7'h00, compare_output}, 8'h01);
    wr(4'h0, 8'h20);
    wr(4'h0, 8'ha0);
    chk({7'h00, compare_output}, 8'h00);
    wr(4'h0, 8'h80);
    chk({7'h00, compare_output}, 8'h00);
    rchk(4'h5, 8'h00);
    wr(4'h0, 8'h30);
    wr(4'h0, 8'hb0);
    wr(4'h0, 8'h03);
    chk({7'h00, compare_output}, 8'h01);
    wr(4'h0, 8'h00);
    // output mode zero: a forced match must leave the high output alone
    wr(4'h0, 8'h80);
    chk({7'h00, compare_output}, 8'h01);
    // normal mode wrap through zero
    wr(4'h4, 8'h01);
    wr(4'h2, 8'hf0);
    wr(4'h1, 8'h01);
    repeat (30) @(posedge sys_clk);
    wr(4'h1, 8'h00);
    rchk(4'h5, 8'h01);
    chk({7'h00, ovf_irq}, 8'h01);
    chk({7'h00, cmp_irq}, 8'h00);
    @(posedge sys_clk);
    ovf_irq_ack <= 1'b1;
    @(posedge sys_clk);
    ovf_irq_ack <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk({7'h00, ovf_irq}, 8'h00);
    rchk(4'h5, 8'h00);
    // count write equal to compare loses the first match
    wr(4'h3, 8'h40);
    wr(4'h2, 8'h40);
    wr(4'h1, 8'h01);
    repeat (3) @(posedge sys_clk);
    wr(4'h1, 8'h00);
    rchk(4'h5, 8'h00);
    wr(4'h2, 8'h3e);
    wr(4'h1, 8'h01);
    repeat (3) @(posedge sys_clk);
    wr(4'h1, 8'h00);
    rchk(4'h5, 8'h02);
    wr(4'h5, 8'h02);
    rchk(4'h5, 8'h00);
    // clear on match with toggle output and compare interrupt
    wr(4'h4, 8'h02);
    wr(4'h0, 8'h12);
    wr(4'h3, 8'h04);
    wr(4'h2, 8'h00);
    wr(4'h1, 8'h01);
    repeat (40) @(posedge sys_clk);
    wr(4'h1, 8'h00);
    rd(4'h2, v);
    // 42 ticks over a period of five counts leave the counter at 2
    chk(v, 8'h02);
    chk({7'h00, cmp_irq}, 8'h01);
    @(posedge sys_clk);
    cmp_irq_ack <= 1'b1;
    @(posedge sys_clk);
    cmp_irq_ack <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk({7'h00, cmp_irq}, 8'h00);
    // phase correct turns down at the top instead of wrapping
    wr(4'h4, 8'h00);
    wr(4'h0, 8'h01);
    wr(4'h2, 8'hfd);
    wr(4'h1, 8'h01);
    repeat (4) @(posedge sys_clk);
    wr(4'h1, 8'h00);
    rd(4'h2, v);
    // six ticks from fd: fe, ff, then back down to fb
    chk(v, 8'hfb);
    wr(4'h0, 8'h00);
    // crystal clock: a few ticks where the system clock would give 162
    wr(4'h6, 8'h01);
    wr(4'h2, 8'h00);
    wr(4'h1, 8'h01);
    repeat (160) @(posedge sys_clk);
    wr(4'h1, 8'h00);
    rd(4'h2, v);
    chk({7'h00, v >= 8'h03 && v <= 8'h07}, 8'h01);
    finish_test();
  end
endmodule // tcu_timer_test
